// ### core/ldr_pkg.sv
// Shared constants, types and states of the LED driver diagnostic readback block
package ldr_pkg;

    // Seven-bit bus addresses chosen by the dimming strap
    localparam logic [6:0]  LDR_ADDR_LOW_MODES  = 7'h2b;
    localparam logic [6:0]  LDR_ADDR_HIGH_MODES = 7'h2a;

    // Register byte offsets, each register one 16-bit word
    localparam logic [7:0]  LDR_OFS_DUTY  = 8'h18;
    localparam logic [7:0]  LDR_OFS_CURR  = 8'h1a;
    localparam logic [7:0]  LDR_OFS_BOOST = 8'h1c;
    localparam logic [7:0]  LDR_OFS_STRAP = 8'h1e;

    // Field widths and positions
    localparam int          LDR_DUTY_W     = 16;
    localparam int          LDR_DAC_W      = 12;
    localparam int          LDR_VCODE_W    = 11;
    localparam int          LDR_STRAP_W    = 3;
    localparam int          LDR_POS_DIMF   = 12;
    localparam int          LDR_POS_GROUP  = 8;
    localparam int          LDR_POS_SWF    = 3;
    localparam int          LDR_POS_MODE   = 0;
    localparam int          LDR_MODE_ABIT  = 2;

    // Reset and framing values
    localparam logic [15:0] LDR_RESET_WORD = 16'h0000;
    localparam logic [3:0]  LDR_BYTE_BITS  = 4'h8;
    localparam logic [1:0]  LDR_IDX_DEV    = 2'h0;
    localparam logic [1:0]  LDR_IDX_REG    = 2'h1;
    localparam logic [1:0]  LDR_IDX_DATA   = 2'h2;

    // Strap detection results; codes as listed in the top module header
    typedef struct packed {
        logic [2:0] dim_frequency;
        logic [2:0] string_grouping;
        logic [2:0] switching_frequency;
        logic [2:0] dimming_mode;
    } ldr_strap_t;

    // Live values from the brightness and boost paths
    typedef struct packed {
        logic [15:0] output_duty;
        logic [11:0] channel_dac_code;
        logic [10:0] adaptive_voltage_code;
    } ldr_live_t;

    // Serial slave states
    typedef enum logic [4:0] {
        LDR_IDLE = 5'h01,
        LDR_RECV = 5'h02,
        LDR_SACK = 5'h04,
        LDR_SEND = 5'h08,
        LDR_MACK = 5'h10
    } ldr_state_t;

endpackage

// ### core/ldr_readback.sv
// Diagnostic readback registers with their serial bus slave
// Behaviour
// - duty register shows the configured output PWM duty across all 16 bits.
// - current register bits 11-0 give the channel DAC code, 15-12 read zero.
// - boost register bits 10-0 give the voltage code, 15-11 read zero.
// - strap bits 14-12 give dim frequency, 152 Hz up to 19531 Hz.
// - strap bits 10-8 give grouping; codes 0-4 mean six down to two strings.
// - grouping codes 5-7 mean outputs tied in three, two or one groups.
// - strap bits 5-3 give switching frequency, 100 kHz up to 2222 kHz.
// - strap bits 2-0 give dimming strap; low bits select the dimming mode.
// - answer at address 0x2B for dimming codes 0-3, at 0x2A for 4-7.
// - all registers read-only and zero after reset, reserved bits included.
`timescale 1ns/10ps
`default_nettype none

module ldr_readback
    import ldr_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    input  wire ldr_live_t  live_in,
    input  wire logic       strap_load_in,
    input  wire ldr_strap_t strap_in,
    output logic [6:0]      dev_addr_out
);

    // Pin synchronisers and edge history
    logic       scl_m_ff;
    logic       scl_s_ff;
    logic       scl_d_ff;
    logic       sda_m_ff;
    logic       sda_s_ff;
    logic       sda_d_ff;

    // Held register contents
    ldr_live_t  live_ff;
    ldr_strap_t strap_ff;
    logic [6:0] dev_addr_ff;
    logic [6:0] nxt_dev_addr;

    // Serial slave state
    ldr_state_t state_ff;
    ldr_state_t nxt_state;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic [7:0] shift_ff;
    logic [7:0] nxt_shift;
    logic [7:0] ptr_ff;
    logic [7:0] nxt_ptr;
    logic [1:0] idx_ff;
    logic [1:0] nxt_idx;
    logic       rw_ff;
    logic       nxt_rw;
    logic       mack_ff;
    logic       nxt_mack;
    logic       oe_ff;
    logic       nxt_oe;
    logic       sda_out_ff;

    // Bus events seen on synchronised pins
    wire logic  scl_rise = scl_s_ff & ~scl_d_ff;
    wire logic  scl_fall = ~scl_s_ff & scl_d_ff;
    wire logic  bus_start = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
    wire logic  bus_stop = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;
    wire logic  byte_done = (cnt_ff == LDR_BYTE_BITS);
    wire logic  addr_match = (shift_ff[7:1] == dev_addr_ff);

    // Register words; unused upper bits forced to zero
    logic [15:0] strap_word;
    wire logic [15:0] duty_word = live_ff.output_duty;
    wire logic [15:0] curr_word = {4'h0, live_ff.channel_dac_code};
    wire logic [15:0] boost_word = {5'h00, live_ff.adaptive_voltage_code};

    // Strap fields placed at their positions, reserved bits zero
    always_comb begin
        strap_word = LDR_RESET_WORD;
        strap_word[LDR_POS_DIMF +: LDR_STRAP_W] = strap_ff.dim_frequency;
        strap_word[LDR_POS_GROUP +: LDR_STRAP_W] = strap_ff.string_grouping;
        strap_word[LDR_POS_SWF +: LDR_STRAP_W] = strap_ff.switching_frequency;
        strap_word[LDR_POS_MODE +: LDR_STRAP_W] = strap_ff.dimming_mode;
    end

    // Word select by pointer; low byte at even address, unmapped reads zero
    wire logic sel_duty = (ptr_ff[7:1] == LDR_OFS_DUTY[7:1]);
    wire logic sel_curr = (ptr_ff[7:1] == LDR_OFS_CURR[7:1]);
    wire logic sel_boost = (ptr_ff[7:1] == LDR_OFS_BOOST[7:1]);
    wire logic sel_strap = (ptr_ff[7:1] == LDR_OFS_STRAP[7:1]);
    wire logic [15:0] rd_word = sel_duty ? duty_word :
                                sel_curr ? curr_word :
                                sel_boost ? boost_word :
                                sel_strap ? strap_word : LDR_RESET_WORD;
    wire logic [7:0] rd_byte = ptr_ff[0] ? rd_word[15:8] : rd_word[7:0];

    // Address follows the top dimming strap bit
    assign nxt_dev_addr = strap_ff.dimming_mode[LDR_MODE_ABIT] ? LDR_ADDR_HIGH_MODES
                                                               : LDR_ADDR_LOW_MODES;

    // Slave sequencing: receive, acknowledge, send, sample master acknowledge
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_shift = shift_ff;
        nxt_ptr   = ptr_ff;
        nxt_idx   = idx_ff;
        nxt_rw    = rw_ff;
        nxt_mack  = mack_ff;
        nxt_oe    = oe_ff;
        if (bus_start) begin
            nxt_state = LDR_RECV;
            nxt_cnt   = 4'h0;
            nxt_idx   = LDR_IDX_DEV;
            nxt_oe    = 1'b0;
        end else if (bus_stop) begin
            nxt_state = LDR_IDLE;
            nxt_oe    = 1'b0;
        end else begin
            unique case (state_ff)
                LDR_IDLE: begin
                    nxt_oe = 1'b0;
                end
                LDR_RECV: begin
                    if (scl_rise) begin
                        nxt_shift = {shift_ff[6:0], sda_s_ff};
                        nxt_cnt   = cnt_ff + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        nxt_cnt = 4'h0;
                        if (idx_ff == LDR_IDX_DEV) begin
                            if (addr_match) begin
                                nxt_rw    = shift_ff[0];
                                nxt_oe    = 1'b1;
                                nxt_state = LDR_SACK;
                                nxt_idx   = LDR_IDX_REG;
                            end else begin
                                nxt_state = LDR_IDLE;
                            end
                        end else begin
                            nxt_oe    = 1'b1;
                            nxt_state = LDR_SACK;
                            if (idx_ff == LDR_IDX_REG) begin
                                nxt_ptr = shift_ff;
                                nxt_idx = LDR_IDX_DATA;
                            end else begin
                                nxt_ptr = ptr_ff + 8'h01;
                            end
                        end
                    end
                end
                LDR_SACK: begin
                    if (scl_fall) begin
                        if (rw_ff) begin
                            nxt_shift = rd_byte;
                            nxt_oe    = ~rd_byte[7];
                            nxt_state = LDR_SEND;
                        end else begin
                            nxt_oe    = 1'b0;
                            nxt_state = LDR_RECV;
                        end
                    end
                end
                LDR_SEND: begin
                    if (scl_rise) begin
                        nxt_cnt = cnt_ff + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        nxt_oe    = 1'b0;
                        nxt_cnt   = 4'h0;
                        nxt_ptr   = ptr_ff + 8'h01;
                        nxt_state = LDR_MACK;
                    end else if (scl_fall) begin
                        nxt_shift = {shift_ff[6:0], 1'b0};
                        nxt_oe    = ~shift_ff[6];
                    end
                end
                LDR_MACK: begin
                    if (scl_rise) begin
                        nxt_mack = ~sda_s_ff;
                    end else if (scl_fall && mack_ff) begin
                        nxt_shift = rd_byte;
                        nxt_oe    = ~rd_byte[7];
                        nxt_state = LDR_SEND;
                    end else if (scl_fall) begin
                        nxt_state = LDR_IDLE;
                    end
                end
                default: begin
                    nxt_state = LDR_IDLE;
                    nxt_oe    = 1'b0;
                end
            endcase
        end
    end

    // Synchronisers and edge history
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            {scl_m_ff, scl_s_ff, scl_d_ff} <= 3'h7;
            {sda_m_ff, sda_s_ff, sda_d_ff} <= 3'h7;
        end else begin
            {scl_m_ff, scl_s_ff, scl_d_ff} <= {scl_in, scl_m_ff, scl_s_ff};
            {sda_m_ff, sda_s_ff, sda_d_ff} <= {sda_in, sda_m_ff, sda_s_ff};
        end
    end

    // Register contents: live values track, straps load on strobe only
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            live_ff     <= '0;
            strap_ff    <= '0;
            dev_addr_ff <= LDR_ADDR_LOW_MODES;
        end else begin
            live_ff     <= live_in;
            strap_ff    <= strap_load_in ? strap_in : strap_ff;
            dev_addr_ff <= nxt_dev_addr;
        end
    end

    // Slave state registers
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state_ff   <= LDR_IDLE;
            cnt_ff     <= 4'h0;
            shift_ff   <= 8'h00;
            ptr_ff     <= 8'h00;
            idx_ff     <= LDR_IDX_DEV;
            rw_ff      <= 1'b0;
            mack_ff    <= 1'b0;
            oe_ff      <= 1'b0;
            sda_out_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            shift_ff   <= nxt_shift;
            ptr_ff     <= nxt_ptr;
            idx_ff     <= nxt_idx;
            rw_ff      <= nxt_rw;
            mack_ff    <= nxt_mack;
            oe_ff      <= nxt_oe;
            sda_out_ff <= 1'b0;
        end
    end

    assign sda_out      = sda_out_ff;
    assign sda_oe_out   = oe_ff;
    assign dev_addr_out = dev_addr_ff;

    // Checks on the register path and slave
    sequence s_load;
        strap_load_in ##1 1'b1;
    endsequence

    sequence s_stop;
        bus_stop ##1 1'b1;
    endsequence

    property p_duty_track;
        @(posedge clk_in) disable iff (!resetn_in)
        resetn_in ##1 sel_duty |-> duty_word == $past(live_in.output_duty);
    endproperty
    a_duty_track: assert property (p_duty_track) else $error("duty word mismatch");

    property p_curr_word;
        @(posedge clk_in) disable iff (!resetn_in)
        $past(resetn_in) |-> curr_word[15:12] == 4'h0 && curr_word[11:0] == $past(live_in.channel_dac_code);
    endproperty
    a_curr_word: assert property (p_curr_word) else $error("current word wrong");

    property p_boost_word;
        @(posedge clk_in) disable iff (!resetn_in)
        $past(resetn_in) |-> boost_word[15:11] == 5'h00 && boost_word[10:0] == $past(live_in.adaptive_voltage_code);
    endproperty
    a_boost_word: assert property (p_boost_word) else $error("boost word wrong");

    property p_strap_load;
        @(posedge clk_in) disable iff (!resetn_in)
        s_load |-> strap_word[LDR_POS_DIMF +: LDR_STRAP_W] == $past(strap_in.dim_frequency, 1)
               && strap_word[LDR_POS_SWF +: LDR_STRAP_W] == $past(strap_in.switching_frequency, 1);
    endproperty
    a_strap_load: assert property (p_strap_load) else $error("strap fields not loaded");

    property p_strap_hold;
        @(posedge clk_in) disable iff (!resetn_in)
        !strap_load_in |=> $stable(strap_word);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed without load");

    // Full layout spelled out, so a misplaced field or a set reserved bit shows
    property p_strap_reserved;
        @(posedge clk_in) disable iff (!resetn_in)
        strap_word == {1'h0, strap_ff.dim_frequency, 1'h0, strap_ff.string_grouping,
                       2'h0, strap_ff.switching_frequency, strap_ff.dimming_mode};
    endproperty
    a_strap_reserved: assert property (p_strap_reserved) else $error("reserved strap bits set");

    property p_addr_select;
        @(posedge clk_in) disable iff (!resetn_in)
        s_load ##1 1'b1 |-> dev_addr_out == ($past(strap_in.dimming_mode[LDR_MODE_ABIT], 2)
                                             ? LDR_ADDR_HIGH_MODES : LDR_ADDR_LOW_MODES);
    endproperty
    a_addr_select: assert property (p_addr_select) else $error("bus address wrong");

    property p_reset_zero;
        @(posedge clk_in)
        !resetn_in |=> live_ff == '0 && strap_ff == '0 && !sda_oe_out;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("not zero after reset");

    property p_stop_release;
        @(posedge clk_in) disable iff (!resetn_in)
        s_stop |-> state_ff == LDR_IDLE && !sda_oe_out;
    endproperty
    a_stop_release: assert property (p_stop_release) else $error("bus held after stop");

    property p_write_ack;
        @(posedge clk_in) disable iff (!resetn_in)
        state_ff == LDR_RECV && idx_ff == LDR_IDX_DATA && scl_fall && byte_done && !bus_start && !bus_stop
            |=> sda_oe_out && state_ff == LDR_SACK;
    endproperty
    a_write_ack: assert property (p_write_ack) else $error("write byte not acknowledged");

endmodule

`default_nettype wire

// ### tb/ldr_host_model.sv
// Bus host model driving the serial clock and open-drain data line
`timescale 1ns/10ps
`default_nettype none

module ldr_host_model (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    // Idle bus, both lines released
    initial begin
        scl_out     = 1'b1;
        sda_low_out = 1'b0;
    end

    // Wait whole system clocks
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // Start or repeated start; ends with clock low
    task automatic start_cond();
        sda_low_out <= 1'b0;
        tick(8);
        scl_out <= 1'b1;
        tick(8);
        sda_low_out <= 1'b1;
        tick(8);
        scl_out <= 1'b0;
        tick(2);
    endtask

    // Stop; both lines left released
    task automatic stop_cond();
        sda_low_out <= 1'b1;
        tick(8);
        scl_out <= 1'b1;
        tick(8);
        sda_low_out <= 1'b0;
        tick(8);
    endtask

    // One bit: data set while clock low, line sampled mid-high
    task automatic clock_bit(input logic b, output logic seen);
        sda_low_out <= ~b;
        tick(8);
        scl_out <= 1'b1;
        tick(4);
        seen = sda_in;
        tick(4);
        scl_out <= 1'b0;
        tick(2);
    endtask

    // Eight bits MSB first, then the acknowledge slot
    task automatic xfer_byte(input logic [7:0] tx, input logic ninth,
                             output logic [7:0] rx, output logic ninth_seen);
        for (int i = 7; i >= 0; i--) begin
            clock_bit(tx[i], rx[i]);
        end
        clock_bit(ninth, ninth_seen);
    endtask
endmodule
`default_nettype wire

// ### tb/ldr_readback_tb.sv
// Self-checking bench for the diagnostic readback block
`timescale 1ns/10ps
`default_nettype none

module ldr_readback_tb;
    import ldr_pkg::*;
    logic       clk_in     = 1'b0;
    logic       resetn_in  = 1'b0;
    logic       strap_load = 1'b0;
    ldr_live_t  live       = '0;
    ldr_strap_t strap      = 12'hfff;
    logic       scl;
    logic       host_low;
    logic       sda_drv;
    logic       sda_oe;
    logic [6:0] dev_addr;
    wire        sda;
    int         miscompares = 0;
    int         check_count = 0;
    int         cycles      = 0;

    // Open-drain data line with pull-up
    assign sda = ~(host_low | (sda_oe & ~sda_drv));

    ldr_readback dut (
        .clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_drv), .sda_oe_out(sda_oe), .live_in(live),
        .strap_load_in(strap_load), .strap_in(strap), .dev_addr_out(dev_addr));

    ldr_host_model host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(host_low));

    always #25 clk_in = ~clk_in;

    // Hang guard
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            miscompares = miscompares + 1;
            finish_test();
        end
    end

    task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_ack(input string name, input logic exp, input logic got);
        chk_word(name, {15'h0, exp}, {15'h0, got});
    endtask

    // Pointer write, repeated start, two data bytes low first
    task automatic reg_read(input logic [6:0] a, input logic [7:0] ptr,
                            output logic [15:0] d, output logic ok);
        logic [7:0] rx;
        logic       k0, k1, k2, k3;
        host.start_cond();
        host.xfer_byte({a, 1'b0}, 1'b1, rx, k0);
        host.xfer_byte(ptr, 1'b1, rx, k1);
        host.start_cond();
        host.xfer_byte({a, 1'b1}, 1'b1, rx, k2);
        host.xfer_byte(8'hff, 1'b0, d[7:0], k3);
        host.xfer_byte(8'hff, 1'b1, d[15:8], k3);
        host.stop_cond();
        ok = !k0 && !k1 && !k2;
    endtask

    task automatic reg_write(input logic [6:0] a, input logic [7:0] ptr,
                             input logic [15:0] w, output logic ok);
        logic [7:0] rx;
        logic       k0, k1, k2, k3;
        host.start_cond();
        host.xfer_byte({a, 1'b0}, 1'b1, rx, k0);
        host.xfer_byte(ptr, 1'b1, rx, k1);
        host.xfer_byte(w[7:0], 1'b1, rx, k2);
        host.xfer_byte(w[15:8], 1'b1, rx, k3);
        host.stop_cond();
        ok = !k0 && !k1 && !k2 && !k3;
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [15:0] d;
        logic [15:0] exp;
        logic [6:0]  a;
        logic        ok;
        repeat (5) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk_word("addr_reset", 16'h002b, {9'h0, dev_addr});
        // Straps presented but never loaded: all words stay zero
        for (int r = 0; r < 4; r++) begin
            reg_read(7'h2b, LDR_OFS_DUTY + 8'(2 * r), d, ok);
            chk_word("reset_word", 16'h0000, d);
        end
        // Live values, all ones exposes the reserved bits
        for (int v = 0; v < 2; v++) begin
            live <= v ? {16'h5a3c, 12'h9e1, 11'h2b4} : '1;
            @(posedge clk_in);
            reg_read(7'h2b, LDR_OFS_DUTY, d, ok);
            chk_ack("read_ack", 1'b1, ok);
            chk_word("duty", live.output_duty, d);
            reg_read(7'h2b, LDR_OFS_CURR, d, ok);
            chk_word("dac_code", {4'h0, live.channel_dac_code}, d);
            // Host turns this code into the boost voltage
            reg_read(7'h2b, LDR_OFS_BOOST, d, ok);
            chk_word("boost_code", {5'h00, live.adaptive_voltage_code}, d);
        end
        // Every strap code, with address switch and a wrong-address probe
        for (int k = 0; k < 8; k++) begin
            strap      <= {3'(k), 3'(7 - k), 3'(k + 3), 3'(k)};
            strap_load <= 1'b1;
            @(posedge clk_in);
            strap_load <= 1'b0;
            repeat (3) @(posedge clk_in);
            a   = (k < 4) ? 7'h2b : 7'h2a;
            exp = {1'h0, 3'(k), 1'h0, 3'(7 - k), 2'h0, 3'(k + 3), 3'(k)};
            chk_word("bus_addr", {9'h0, a}, {9'h0, dev_addr});
            reg_read(a, LDR_OFS_STRAP, d, ok);
            chk_ack("strap_ack", 1'b1, ok);
            chk_word("strap_word", exp, d);
            reg_read(a ^ 7'h01, LDR_OFS_STRAP, d, ok);
            chk_ack("foreign_addr_ack", 1'b0, ok);
        end
        // Writes are acknowledged and discarded
        reg_write(7'h2a, LDR_OFS_STRAP, 16'hffff, ok);
        chk_ack("write_ack", 1'b1, ok);
        reg_read(7'h2a, LDR_OFS_STRAP, d, ok);
        chk_word("strap_after_write", exp, d);
        reg_read(7'h2a, 8'h20, d, ok);
        chk_word("unmapped", 16'h0000, d);
        // Second reset clears loaded straps and address choice
        resetn_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk_word("addr_rereset", 16'h002b, {9'h0, dev_addr});
        reg_read(7'h2b, LDR_OFS_STRAP, d, ok);
        chk_word("strap_rereset", 16'h0000, d);
        finish_test();
    end
endmodule
`default_nettype wire
